// ### logic/clock_gen.sv
// system clock source selection, start-up sequencing and peripheral/cpu prescaler
`timescale 1ns/1ps
`default_nettype none
module clock_gen
    import clock_gen_pkg::*;
#(
    parameter int HALT_CYCLES = clock_gen_pkg::POC_STOP_CYCLES,
    parameter int WAIT_EXP_00 = clock_gen_pkg::WAIT_EXP_0,
    parameter int WAIT_EXP_01 = clock_gen_pkg::WAIT_EXP_1,
    parameter int WAIT_EXP_10 = clock_gen_pkg::WAIT_EXP_2,
    parameter int WAIT_EXP_11 = clock_gen_pkg::WAIT_EXP_3
) (
    input  wire logic                             pclk,
    input  wire logic                             presetn,
    input  wire logic                             psel,
    input  wire logic                             penable,
    input  wire logic                             pwrite,
    input  wire logic [clock_gen_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                      pwdata,
    output logic [31:0]                           prdata,
    output logic                                  pready,
    output logic                                  pslverr,
    input  wire logic [7:0]                       option_byte,
    input  wire logic                             osc_pin_in,
    input  wire logic                             slow_osc_in,
    input  wire logic                             stop_enter,
    input  wire logic                             wake_event,
    output logic                                  main_clock_tick,
    output logic                                  periph_tick,
    output logic                                  cpu_tick,
    output logic                                  periph_clk_q,
    output logic                                  cpu_clk_q,
    output logic                                  slow_internal_clock,
    output logic                                  cpu_run_q,
    output logic                                  osc_pin_in_port_en_q,
    output logic                                  osc_pin_out_port_en_q,
    output logic [1:0]                            clock_source_q
);

    import clock_gen_pkg::*;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    start_state_t            state_q;
    start_state_t            state_d;
    logic [STOP_CNT_W-1:0]   halt_cnt_q;
    logic [WAIT_CNT_W-1:0]   wait_cnt_q;
    logic [WAIT_CNT_W-1:0]   wait_limit_q;
    logic                    wait_load;
    logic [1:0]              wait_code;
    logic [7:0]              opt_meta_q;
    logic [7:0]              opt_sync_q;
    logic [2:0]              osc_sync_q;
    logic [1:0]              slow_sync_q;
    logic                    slow_level_q;
    logic                    osc_rise;
    logic                    src_tick;
    logic                    cpu_div_select_bit;
    logic [1:0]              peripheral_prescale_control;
    logic [1:0]              stop_wake_wait_select;
    logic [1:0]              cpu_shift;
    logic                    halt_done;
    logic                    wait_done;
    logic                    setup;
    logic                    wr_en;
    logic                    addr_ok;
    logic                    bad_write;
    logic [31:0]             prdata_q;
    logic                    err_q;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    // option byte and pins come from outside pclk: two flops for the option byte, three for each pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            opt_meta_q <= 8'h00;
            opt_sync_q <= 8'h00;
        end else begin
            opt_meta_q <= option_byte;
            opt_sync_q <= opt_meta_q;
        end
    end

    // third flop feeds the edge detector; the first is read by the second only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_sync_q <= 3'h0;
        end else begin
            osc_sync_q <= {osc_sync_q[1:0], osc_pin_in};
        end
    end

    // slow oscillator, kept apart from the prescaler chain
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slow_sync_q  <= 2'h0;
            slow_level_q <= 1'b0;
        end else begin
            slow_sync_q  <= {slow_sync_q[0], slow_osc_in};
            slow_level_q <= slow_sync_q[1];
        end
    end
    assign slow_internal_clock = slow_level_q;

    // ------------------------------------------------------------
    // main clock source
    // ------------------------------------------------------------
    // internal oscillator modelled as pclk itself; the pin sources count rising edges
    assign osc_rise = osc_sync_q[1] && !osc_sync_q[2];
    always_comb begin
        case (clock_source_q)
            SRC_INTERNAL:  src_tick = 1'b1;
            SRC_RESONATOR: src_tick = osc_rise;
            SRC_EXTERNAL:  src_tick = osc_rise;
            default:       src_tick = 1'b0;
        endcase
    end

    // main clock reaches the prescaler only while the cpu may run
    assign main_clock_tick = src_tick && (state_q == ST_RUN);

    // ------------------------------------------------------------
    // source choice and pin ownership, taken once from the option byte
    // ------------------------------------------------------------
    // a reserved source code falls back to the internal oscillator
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clock_source_q        <= SRC_INTERNAL;
            osc_pin_in_port_en_q  <= 1'b0;
            osc_pin_out_port_en_q <= 1'b0;
        end else if (state_q == ST_READ_OPT) begin
            case (opt_sync_q[OPT_SRC_LSB +: 2])
                SRC_RESONATOR: begin
                    clock_source_q        <= SRC_RESONATOR;
                    osc_pin_in_port_en_q  <= 1'b0;
                    osc_pin_out_port_en_q <= 1'b0;
                end
                SRC_EXTERNAL: begin
                    clock_source_q        <= SRC_EXTERNAL;
                    osc_pin_in_port_en_q  <= 1'b0;
                    osc_pin_out_port_en_q <= 1'b1;
                end
                default: begin
                    clock_source_q        <= SRC_INTERNAL;
                    osc_pin_in_port_en_q  <= 1'b1;
                    osc_pin_out_port_en_q <= 1'b1;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // start-up and stop sequencing
    // ------------------------------------------------------------
    assign halt_done = (halt_cnt_q >= STOP_CNT_W'(HALT_CYCLES - 1));
    assign wait_done = src_tick && (wait_cnt_q >= wait_limit_q);

    // halt interval after power-on reset before anything starts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            halt_cnt_q <= '0;
        end else if (state_q == ST_HALT && !halt_done) begin
            halt_cnt_q <= halt_cnt_q + 1'b1;
        end
    end

    // state transitions
    always_comb begin
        state_d   = state_q;
        wait_load = 1'b0;
        wait_code = opt_sync_q[OPT_WAIT_LSB +: 2];
        case (state_q)
            ST_HALT: begin
                if (halt_done) begin
                    state_d = ST_READ_OPT;
                end
            end
            ST_READ_OPT: begin
                // option byte decides between an immediate start and a wait
                if (opt_sync_q[OPT_SRC_LSB +: 2] == SRC_RESONATOR) begin
                    state_d   = ST_STABILIZE;
                    wait_load = 1'b1;
                    wait_code = opt_sync_q[OPT_WAIT_LSB +: 2];
                end else begin
                    state_d = ST_RUN;
                end
            end
            ST_STABILIZE: begin
                if (wait_done) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (stop_enter) begin
                    state_d = ST_STOP;
                end
            end
            ST_STOP: begin
                // only the resonator needs to settle again after a wake
                if (wake_event) begin
                    if (clock_source_q == SRC_RESONATOR) begin
                        state_d   = ST_STABILIZE;
                        wait_load = 1'b1;
                        wait_code = stop_wake_wait_select;
                    end else begin
                        state_d = ST_RUN;
                    end
                end
            end
            default: begin
                state_d = ST_HALT;
            end
        endcase
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_HALT;
        end else begin
            state_q <= state_d;
        end
    end

    // stabilization counter counts main clock periods of the chosen source
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_cnt_q   <= '0;
            wait_limit_q <= '0;
        end else if (wait_load) begin
            wait_cnt_q <= '0;
            case (wait_code)
                2'h0:    wait_limit_q <= WAIT_CNT_W'((1 << WAIT_EXP_00) - 1);
                2'h1:    wait_limit_q <= WAIT_CNT_W'((1 << WAIT_EXP_01) - 1);
                2'h2:    wait_limit_q <= WAIT_CNT_W'((1 << WAIT_EXP_10) - 1);
                default: wait_limit_q <= WAIT_CNT_W'((1 << WAIT_EXP_11) - 1);
            endcase
        end else if (state_q == ST_STABILIZE && src_tick) begin
            wait_cnt_q <= wait_cnt_q + 1'b1;
        end
    end

    // cpu may run only in the run state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_run_q <= 1'b0;
        end else begin
            cpu_run_q <= (state_d == ST_RUN);
        end
    end

    // ------------------------------------------------------------
    // prescaler chain
    // ------------------------------------------------------------
    // cpu stage adds /4 when the cpu bit is set, giving /1 to /16 overall
    assign cpu_shift = cpu_div_select_bit ? 2'h2 : 2'h0;

    // peripheral clock from the main clock
    div_stage #(
        .SHIFT_W (2)
    ) u_periph_div (
        .pclk        (pclk),
        .presetn     (presetn),
        .tick_in     (main_clock_tick),
        .shift       (peripheral_prescale_control),
        .shift_reset (PERIPH_DIV_RESET[1:0]),
        .tick_out    (periph_tick),
        .clk_level_q (periph_clk_q)
    );

    // cpu clock from the peripheral clock
    div_stage #(
        .SHIFT_W (2)
    ) u_cpu_div (
        .pclk        (pclk),
        .presetn     (presetn),
        .tick_in     (periph_tick),
        .shift       (cpu_shift),
        .shift_reset (2'h0),
        .tick_out    (cpu_tick),
        .clk_level_q (cpu_clk_q)
    );

    // ------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------
    assign setup   = psel && !penable;
    assign addr_ok = (paddr == CPU_DIV_ADDR) || (paddr == PERIPH_DIV_ADDR)
                  || (paddr == WAKE_WAIT_ADDR) || (paddr == STATUS_ADDR);
    // code 11 is prohibited, so such a write is refused and the old ratio kept
    assign bad_write = pwrite && (paddr == PERIPH_DIV_ADDR) && (pwdata[1:0] == PERIPH_CODE_BAD);
    assign wr_en     = psel && penable && pwrite && addr_ok && !bad_write;

    // zero wait states: access phase always completes
    assign pready  = 1'b1;
    assign pslverr = psel && penable && err_q;
    assign prdata  = prdata_q;

    // divider registers, both 02H out of reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_div_select_bit          <= CPU_DIV_RESET[CPU_DIV_BIT];
            peripheral_prescale_control <= PERIPH_DIV_RESET[1:0];
        end else if (wr_en) begin
            if (paddr == CPU_DIV_ADDR) begin
                cpu_div_select_bit <= pwdata[CPU_DIV_BIT];
            end
            if (paddr == PERIPH_DIV_ADDR) begin
                peripheral_prescale_control <= pwdata[1:0];
            end
        end
    end

    // wake wait select, used only on a stop release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stop_wake_wait_select <= WAKE_WAIT_RESET;
        end else if (wr_en && paddr == WAKE_WAIT_ADDR) begin
            stop_wake_wait_select <= pwdata[1:0];
        end
    end

    // read data and error captured in the setup cycle, stable through access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
            err_q    <= 1'b0;
        end else if (setup) begin
            err_q    <= !addr_ok || bad_write;
            prdata_q <= 32'h0000_0000;
            if (!pwrite) begin
                case (paddr)
                    CPU_DIV_ADDR:    prdata_q[CPU_DIV_BIT] <= cpu_div_select_bit;
                    PERIPH_DIV_ADDR: prdata_q[1:0]         <= peripheral_prescale_control;
                    WAKE_WAIT_ADDR:  prdata_q[1:0]         <= stop_wake_wait_select;
                    STATUS_ADDR: begin
                        prdata_q[STAT_STATE_LSB +: 3] <= state_q;
                        prdata_q[STAT_SRC_LSB +: 2]   <= clock_source_q;
                        prdata_q[STAT_RUN_BIT]        <= cpu_run_q;
                        prdata_q[STAT_STOP_BIT]       <= (state_q == ST_STOP);
                    end
                    default:         prdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule
`default_nettype wire

// ### logic/clock_gen_pkg.sv
// constants, register map and start-up states of the system clock source and prescaler
//
// Overview of operation
// - the peripheral clock divides the selected main clock, and the cpu clock divides the peripheral clock again.
// - peripheral divider code 00 passes the main clock, 01 halves it, 10 quarters it; 11 must never be written.
// - exactly one of internal oscillator, resonator or external clock is the main clock, fixed by the option byte.
// - with the internal oscillator both oscillator pins are handed to the port logic.
// - with the resonator both oscillator pins belong to the resonator and are not port pins.
// - with the external clock the input pin carries the clock and the output pin is a port pin.
// - after the power-on reset the option byte is read and the source chosen before the cpu runs.
// - the internal oscillator starts the cpu with no stabilization wait.
// - the resonator is fed to the cpu only after a wait whose length the option byte gives.
// - the wait after a stop-mode release is timed by the wake wait select register, not the option byte.
// - after the power-on reset operation stays halted for about 544 us before the clock runs.
// - peripherals get the prescaled peripheral clock and, separately, the slow internal clock.
// - the cpu clock is the main clock divided by 1, 2, 4, 8 or 16 from the peripheral code and one cpu bit.
// - both divider registers reset to 02H.
// - wake wait select 00, 01, 10, 11 gives 2^10, 2^12, 2^15, 2^17 main clock periods.
package clock_gen_pkg;

    // ------------------------------------------------------------
    // register indices; byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [15:0] CPU_DIV_INDEX     = 16'hFFFB;
    localparam logic [15:0] PERIPH_DIV_INDEX  = 16'hFFF3;
    localparam logic [15:0] WAKE_WAIT_INDEX   = 16'hFFF4;
    localparam logic [15:0] STATUS_INDEX      = 16'hFFF6;
    localparam int          ADDR_W            = 18;
    localparam logic [ADDR_W-1:0] CPU_DIV_ADDR    = {CPU_DIV_INDEX, 2'b00};
    localparam logic [ADDR_W-1:0] PERIPH_DIV_ADDR = {PERIPH_DIV_INDEX, 2'b00};
    localparam logic [ADDR_W-1:0] WAKE_WAIT_ADDR  = {WAKE_WAIT_INDEX, 2'b00};
    localparam logic [ADDR_W-1:0] STATUS_ADDR     = {STATUS_INDEX, 2'b00};

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int          CPU_DIV_BIT       = 1;
    localparam logic [7:0]  CPU_DIV_RESET     = 8'h02;
    localparam logic [7:0]  PERIPH_DIV_RESET  = 8'h02;
    localparam logic [1:0]  PERIPH_CODE_BAD   = 2'h3;
    localparam logic [1:0]  WAKE_WAIT_RESET   = 2'h0;
    localparam int          OPT_SRC_LSB       = 0;
    localparam int          OPT_WAIT_LSB      = 2;
    localparam int          STAT_STATE_LSB    = 0;
    localparam int          STAT_SRC_LSB      = 4;
    localparam int          STAT_RUN_BIT      = 6;
    localparam int          STAT_STOP_BIT     = 7;

    // source codes in the option byte
    localparam logic [1:0]  SRC_INTERNAL      = 2'h0;
    localparam logic [1:0]  SRC_RESONATOR     = 2'h1;
    localparam logic [1:0]  SRC_EXTERNAL      = 2'h2;

    // wait exponents for codes 00..11, in main clock periods
    localparam int          WAIT_EXP_0        = 10;
    localparam int          WAIT_EXP_1        = 12;
    localparam int          WAIT_EXP_2        = 15;
    localparam int          WAIT_EXP_3        = 17;
    localparam int          WAIT_CNT_W        = 18;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int          CLK_PERIOD_PS     = 10000;
    localparam int          POC_STOP_TIME_NS  = 544000;
    localparam int          POC_STOP_CYCLES   = (POC_STOP_TIME_NS * 1000) / CLK_PERIOD_PS;
    localparam int          STOP_CNT_W        = 20;

    // start-up sequence
    typedef enum logic [2:0] {
        ST_HALT,
        ST_READ_OPT,
        ST_STABILIZE,
        ST_RUN,
        ST_STOP
    } start_state_t;

endpackage

// ### logic/div_stage.sv
// one power-of-two divider stage producing a tick pulse and a square clock level
`timescale 1ns/1ps
`default_nettype none
module div_stage #(
    parameter int SHIFT_W = 2
) (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               tick_in,
    input  wire logic [SHIFT_W-1:0] shift,
    input  wire logic [SHIFT_W-1:0] shift_reset,
    output logic                    tick_out,
    output logic                    clk_level_q
);

    localparam int CNT_W = (1 << SHIFT_W) - 1;

    logic [CNT_W-1:0]   count_q;
    logic [SHIFT_W-1:0] shift_q;
    logic [CNT_W-1:0]   limit;
    logic               wrap;
    logic               seeded_q;

    // ------------------------------------------------------------
    // divide
    // ------------------------------------------------------------
    // limit is 2^shift - 1 input ticks
    assign limit    = CNT_W'((1 << shift_q) - 1);
    assign wrap     = tick_in && (count_q == limit);
    assign tick_out = wrap;

    // counter restarts at each wrap
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= '0;
        end else if (wrap) begin
            count_q <= '0;
        end else if (tick_in) begin
            count_q <= count_q + 1'b1;
        end
    end

    // new ratio is taken only at a period boundary, never mid-period
    // seeding from shift_reset is done once after reset, a clocked capture
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift_q  <= '0;
            seeded_q <= 1'b0;
        end else if (!seeded_q) begin
            shift_q  <= shift_reset;
            seeded_q <= 1'b1;
        end else if (wrap) begin
            shift_q  <= shift;
        end
    end

    // square level toggles once per output period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_level_q <= 1'b0;
        end else if (wrap) begin
            clk_level_q <= ~clk_level_q;
        end
    end

endmodule
`default_nettype wire

// ### sim/clock_gen_chk.sv
// port-level assertions for the clock generator
`timescale 1ns/1ps
`default_nettype none
module clock_gen_chk
    import clock_gen_pkg::*;
#(
    parameter int HALT_CYCLES = 20
) (
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic              pslverr,
    input wire logic [7:0]        option_byte,
    input wire logic              main_clock_tick,
    input wire logic              periph_tick,
    input wire logic              cpu_tick,
    input wire logic              cpu_run_q,
    input wire logic              osc_pin_in_port_en_q,
    input wire logic              osc_pin_out_port_en_q,
    input wire logic [1:0]        clock_source_q
);
    // slack around the halt count covers sync and option read
    localparam int H_LO = HALT_CYCLES - 12;
    localparam int H_HI = HALT_CYCLES + 2;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // --------------------------------
    // start-up and divider chain
    // --------------------------------
    sequence s_halted;
        !cpu_run_q [*8];
    endsequence
    AST_HALT: assert property ($rose(presetn) && option_byte[1:0] == SRC_INTERNAL
        |-> s_halted ##[H_LO:H_HI] cpu_run_q) else $error("halt length wrong");
    AST_NO_CPU_TICK_HALTED: assert property (!cpu_run_q |-> !cpu_tick)
        else $error("cpu tick while halted");
    AST_PERIPH_FROM_MAIN: assert property (periph_tick |-> main_clock_tick)
        else $error("peripheral tick without main tick");
    AST_CPU_FROM_PERIPH: assert property (cpu_tick |-> periph_tick)
        else $error("cpu tick without peripheral tick");
    AST_BAD_CODE: assert property (psel && penable && pwrite && paddr == PERIPH_DIV_ADDR
        && pwdata[1:0] == PERIPH_CODE_BAD |-> pslverr) else $error("code 11 accepted");
    // --------------------------------
    // oscillator pin ownership
    // --------------------------------
    AST_PINS_INTERNAL: assert property (cpu_run_q
        && clock_source_q == SRC_INTERNAL |-> osc_pin_in_port_en_q && osc_pin_out_port_en_q)
        else $error("pins not released");
    AST_PINS_RESONATOR: assert property (clock_source_q == SRC_RESONATOR
        |-> !osc_pin_in_port_en_q && !osc_pin_out_port_en_q) else $error("resonator pin released");
    AST_PINS_EXTERNAL: assert property (cpu_run_q
        && clock_source_q == SRC_EXTERNAL |-> !osc_pin_in_port_en_q && osc_pin_out_port_en_q)
        else $error("external pins wrong");
endmodule
bind clock_gen clock_gen_chk #(.HALT_CYCLES(HALT_CYCLES)) clock_gen_chk_i (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pslverr, .option_byte, .main_clock_tick, .periph_tick,
    .cpu_tick, .cpu_run_q, .osc_pin_in_port_en_q, .osc_pin_out_port_en_q, .clock_source_q);
`default_nettype wire

// ### sim/tb_clock_gen.sv
// self-checking testbench for the clock generator
`timescale 1ns/1ps
`default_nettype none
module tb_clock_gen;
    import clock_gen_pkg::*;
    typedef struct packed {logic w; logic [17:0] a; logic [7:0] d; logic [7:0] r; logic e;} row_t;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, osc_pin_in = 0, slow_osc_in = 0;
    logic stop_enter = 0, wake_event = 0, pready, pslverr, e, x, main_clock_tick, periph_tick, cpu_tick;
    logic slow_internal_clock, cpu_run_q, osc_pin_in_port_en_q, osc_pin_out_port_en_q, periph_clk_q, cpu_clk_q;
    logic [17:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [7:0]  option_byte = 8'h00;
    logic [1:0]  clock_source_q;
    int          err_total = 0, n_checks = 0, n, m, p, c;
    row_t        rows [9] = '{'{1'h0, CPU_DIV_ADDR, 8'h00, 8'h02, 1'h0},
        '{1'h0, PERIPH_DIV_ADDR, 8'h00, 8'h02, 1'h0}, '{1'h0, WAKE_WAIT_ADDR, 8'h00, 8'h00, 1'h0},
        '{1'h0, STATUS_ADDR, 8'h00, 8'h43, 1'h0}, '{1'h1, PERIPH_DIV_ADDR, 8'h03, 8'h00, 1'h1},
        '{1'h0, PERIPH_DIV_ADDR, 8'h00, 8'h02, 1'h0}, '{1'h0, 18'h00000, 8'h00, 8'h00, 1'h1},
        '{1'h1, WAKE_WAIT_ADDR, 8'h03, 8'h00, 1'h0}, '{1'h0, WAKE_WAIT_ADDR, 8'h00, 8'h03, 1'h0}};
    // short counts keep the run brief
    clock_gen #(.HALT_CYCLES(20), .WAIT_EXP_00(2), .WAIT_EXP_01(3), .WAIT_EXP_10(4), .WAIT_EXP_11(5))
        clock_gen_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .option_byte, .osc_pin_in, .slow_osc_in, .stop_enter, .wake_event, .main_clock_tick,
        .periph_tick, .cpu_tick, .periph_clk_q, .cpu_clk_q, .slow_internal_clock, .cpu_run_q,
        .osc_pin_in_port_en_q, .osc_pin_out_port_en_q, .clock_source_q);
    // clock, resonator stand-in and slow oscillator
    always #5 pclk = ~pclk;
    always @(posedge pclk) osc_pin_in <= ~osc_pin_in;
    always @(posedge osc_pin_in) slow_osc_in <= ~slow_osc_in;
    // --------------------------------
    // helpers
    // --------------------------------
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // caller releases psel, so back-to-back setups never assign it twice
    task apb(input logic w, input logic [17:0] a, input logic [31:0] d);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1) @(posedge pclk);
        rd = prdata;
        e = pslverr;
        penable <= 1'h0;
    endtask
    task wait_run;
        n = 0;
        while (cpu_run_q !== 1'h1) begin
            @(posedge pclk);
            n++;
        end
    endtask
    task rst(input logic [7:0] ob);
        option_byte <= ob;
        presetn <= 1'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        wait_run;
    endtask
    task stop_wake;
        stop_enter <= 1'h1;
        @(posedge pclk);
        stop_enter <= 1'h0;
        @(posedge pclk);
        chk(cpu_run_q, 0);
        wake_event <= 1'h1;
        @(posedge pclk);
        wake_event <= 1'h0;
        wait_run;
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // --------------------------------
    // tests
    // --------------------------------
    initial begin
        // every source, start-up wait code 01
        for (int s = 0; s < 3; s++) begin
            rst(8'(8'h04 | s));
            chk(clock_source_q, s);
            chk({osc_pin_in_port_en_q, osc_pin_out_port_en_q}, s == 0 ? 3 : s == 1 ? 0 : 1);
            chk(s == 1 ? n >= 34 : n <= 24, 1);
        end
        $display("source test done");
        rst(8'h00);
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, {24'h0, rows[i].d});
            if (!rows[i].w) chk(rd, {24'h0, rows[i].r});
            chk(e, rows[i].e);
        end
        psel <= 1'h0;
        @(posedge pclk);
        $display("register test done");
        // all legal ratio pairs; a 64-cycle window holds whole periods
        for (int k = 0; k < 6; k++) begin
            p = k % 3;
            c = k / 3;
            apb(1'h1, PERIPH_DIV_ADDR, p);
            apb(1'h1, CPU_DIV_ADDR, c << CPU_DIV_BIT);
            psel <= 1'h0;
            repeat (40) @(posedge pclk);
            n = 0;
            m = 0;
            repeat (64) begin
                @(posedge pclk);
                n += periph_tick + periph_clk_q;
                m += cpu_tick + cpu_clk_q;
            end
            chk(n, (64 >> p) + 32);
            chk(m, (64 >> (p + 2 * c)) + 32);
        end
        $display("divider test done");
        stop_wake;
        chk(n <= 3, 1);
        x = slow_internal_clock;
        repeat (6) @(posedge pclk);
        chk(slow_internal_clock, !x);
        rst(8'h01);
        apb(1'h1, WAKE_WAIT_ADDR, 3);
        psel <= 1'h0;
        @(posedge pclk);
        stop_wake;
        chk(n >= 60 && n <= 75, 1);
        $display("stop test done");
        finish_test;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        err_total++;
        finish_test;
    end
endmodule
`default_nettype wire
